// ===== core/dso_regs.svh
// Constants for the drive status output block
`ifndef DSO_REGS_SVH
`define DSO_REGS_SVH

// Frequency word width (drive frequency units)
`define DSO_FREQ_W      16
// Number of status output terminals
`define DSO_NUM_TERM    2
// Function select width and codes
`define DSO_FSEL_W      8
`define DSO_FSEL_RUN    8'h00
`define DSO_FSEL_SPEED  8'h01
`define DSO_FSEL_ABOVE  8'h02
// Arrival band, percent of maximum frequency
`define DSO_FON_PCT     32'd1
`define DSO_FOFF_PCT    32'd2
`define DSO_PCT_DEN     32'd100
// Reset values
`define DSO_IND_RST     1'b0
`define DSO_OE_RST      1'b0
`define DSO_PIN_LOW     1'b0

`endif

// ===== core/dso_pkg.sv
// Types shared by the drive status output block
package dso_pkg;

    typedef enum logic [1:0] {
        DSO_RAMP_CONST,
        DSO_RAMP_ACCEL,
        DSO_RAMP_DECEL
    } dso_ramp_t;

    // Live drive state, from drive logic on the same clock
    typedef struct packed {
        logic        runMode;
        logic        motorOn;
        dso_ramp_t   ramp;
        logic [15:0] outFreq;
    } dso_drive_t;

    // Programmed settings
    typedef struct packed {
        logic [15:0] targetFreq;
        logic [15:0] startFreq;
        logic [15:0] maxFreq;
        logic [15:0] accelOnThr;
        logic [15:0] decelOffThr;
    } dso_cfg_t;

    // Internal indications, high when true
    typedef struct packed {
        logic running;
        logic atSpeed;
        logic aboveThr;
    } dso_ind_t;

endpackage

// ===== core/dso_band_detect.sv
// Hysteresis window detector around a reference frequency
`timescale 1ns/1ps
`default_nettype none
`include "dso_regs.svh"

module dso_band_detect
    import dso_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     enable,
    input  wire logic [`DSO_FREQ_W-1:0]   freq,
    input  wire logic [`DSO_FREQ_W-1:0]   refFreq,
    input  wire logic [`DSO_FREQ_W-1:0]   onBand,
    input  wire logic [`DSO_FREQ_W-1:0]   offBand,
    output logic                          inBand_q
);

    logic [`DSO_FREQ_W-1:0] diff;

    assign diff = (freq >= refFreq) ? freq - refFreq : refFreq - freq;

    // Enter inside the narrow band, leave past the wide one or when disabled
    always_ff @(posedge clock)
    begin
        if (rst || !enable)
            inBand_q <= `DSO_IND_RST;
        else if (diff <= onBand)
            inBand_q <= 1'b1;
        else if (diff > offBand)
            inBand_q <= 1'b0;
    end

endmodule
`default_nettype wire

// ===== core/dso_status_outputs.sv
// Drive status outputs: run, at-speed and over-threshold indications
`timescale 1ns/1ps
`default_nettype none
`include "dso_regs.svh"

module dso_status_outputs
    import dso_pkg::*;
(
    input  wire logic                                     clock,
    input  wire logic                                     rst,
    input  wire dso_drive_t                               drive,
    input  wire dso_cfg_t                                 cfg,
    input  wire logic [`DSO_NUM_TERM*`DSO_FSEL_W-1:0]     termSel,
    output dso_ind_t                                      ind_q,
    output logic [`DSO_NUM_TERM-1:0]                      termOut_q,
    output logic [`DSO_NUM_TERM-1:0]                      termOe_q,
    output logic [`DSO_NUM_TERM-1:0]                      termLevel_n_q
);

    logic                   running_q;
    logic                   atSpeed_q;
    logic                   aboveThr_q;
    logic                   aboveThr_d;
    logic                   inBand;
    logic [`DSO_FREQ_W-1:0] bandOn_q;
    logic [`DSO_FREQ_W-1:0] bandOff_q;

    // Band widths from maximum frequency; widened to avoid overflow
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            bandOn_q  <= '0;
            bandOff_q <= '0;
        end
        else
        begin
            bandOn_q  <= 16'((32'(cfg.maxFreq) * `DSO_FON_PCT) / `DSO_PCT_DEN);
            bandOff_q <= 16'((32'(cfg.maxFreq) * `DSO_FOFF_PCT) / `DSO_PCT_DEN);
        end
    end

    // Run indication: set past start frequency, held until stop mode
    always_ff @(posedge clock)
    begin
        if (rst)
            running_q <= `DSO_IND_RST;
        else if (!drive.runMode)
            running_q <= 1'b0;
        else if (drive.motorOn && drive.outFreq > cfg.startFreq)
            running_q <= 1'b1;
    end

    dso_band_detect u_band (
        .clock    (clock),
        .rst      (rst),
        .enable   (drive.motorOn),
        .freq     (drive.outFreq),
        .refFreq  (cfg.targetFreq),
        .onBand   (bandOn_q),
        .offBand  (bandOff_q),
        .inBand_q (inBand)
    );

    // At-speed: band hit only counts at constant output
    always_ff @(posedge clock)
    begin
        if (rst)
            atSpeed_q <= `DSO_IND_RST;
        else
            atSpeed_q <= drive.motorOn && drive.ramp == DSO_RAMP_CONST && inBand;
    end

    // Over-threshold: set going up, cleared going down, held between
    always_comb
    begin
        aboveThr_d = aboveThr_q;
        if (!drive.motorOn)
            aboveThr_d = 1'b0;
        else
        begin
            unique case (drive.ramp)
                DSO_RAMP_ACCEL:
                begin
                    if (drive.outFreq >= cfg.accelOnThr)
                        aboveThr_d = 1'b1;
                end
                DSO_RAMP_DECEL:
                begin
                    if (drive.outFreq < cfg.decelOffThr)
                        aboveThr_d = 1'b0;
                end
                DSO_RAMP_CONST:
                begin
                    if (drive.outFreq >= cfg.accelOnThr)
                        aboveThr_d = 1'b1;
                    else if (drive.outFreq < cfg.decelOffThr)
                        aboveThr_d = 1'b0;
                end
                default:
                    aboveThr_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            aboveThr_q <= `DSO_IND_RST;
        else
            aboveThr_q <= aboveThr_d;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            ind_q <= '0;
        else
            ind_q <= '{running: running_q, atSpeed: atSpeed_q, aboveThr: aboveThr_q};
    end

    // Terminal routing; unknown codes leave the terminal released
    genvar t;
    generate
        for (t = 0; t < `DSO_NUM_TERM; t++)
        begin : g_term
            logic [`DSO_FSEL_W-1:0] sel;
            logic                   active;

            assign sel = termSel[t*`DSO_FSEL_W +: `DSO_FSEL_W];

            always_comb
            begin
                unique case (sel)
                    `DSO_FSEL_RUN:   active = running_q;
                    `DSO_FSEL_SPEED: active = atSpeed_q;
                    `DSO_FSEL_ABOVE: active = aboveThr_q;
                    default:         active = 1'b0;
                endcase
            end

            // Open collector: only ever pulls low, enable carries the state
            always_ff @(posedge clock)
            begin
                if (rst)
                begin
                    termOut_q[t]     <= `DSO_PIN_LOW;
                    termOe_q[t]      <= `DSO_OE_RST;
                    termLevel_n_q[t] <= 1'b1;
                end
                else
                begin
                    termOut_q[t]     <= `DSO_PIN_LOW;
                    termOe_q[t]      <= active;
                    termLevel_n_q[t] <= !active;
                end
            end
        end
    endgenerate

    // Helper terms for the checks below
    logic [`DSO_FREQ_W-1:0] chkDiff;
    logic                   chkSteady;

    assign chkDiff   = (drive.outFreq >= cfg.targetFreq) ? drive.outFreq - cfg.targetFreq
                                                         : cfg.targetFreq - drive.outFreq;
    assign chkSteady = drive.motorOn && drive.ramp == DSO_RAMP_CONST;

    sequence s_nearTarget;
        chkSteady && $stable(drive.outFreq) && chkDiff <= bandOn_q && $stable(bandOn_q);
    endsequence

    sequence s_settled;
        s_nearTarget ##1 s_nearTarget;
    endsequence

    a_run_stop_clear: assert property (@(posedge clock) disable iff (rst)
        !drive.runMode |=> !running_q)
        else $error("run indication not cleared in stop mode");

    a_run_start_gate: assert property (@(posedge clock) disable iff (rst)
        $rose(running_q) |-> $past(drive.outFreq) > $past(cfg.startFreq) && $past(drive.runMode))
        else $error("run indication set at or below start frequency");

    a_run_set_on: assert property (@(posedge clock) disable iff (rst)
        drive.runMode && drive.motorOn && drive.outFreq > cfg.startFreq |=> running_q)
        else $error("run indication missing while running above start");

    a_speed_ramp_off: assert property (@(posedge clock) disable iff (rst)
        (!drive.motorOn || drive.ramp != DSO_RAMP_CONST) |=> !atSpeed_q)
        else $error("at-speed set while ramping or output off");

    a_speed_band_on: assert property (@(posedge clock) disable iff (rst)
        s_settled |=> atSpeed_q)
        else $error("at-speed missing at steady target frequency");

    a_speed_band_off: assert property (@(posedge clock) disable iff (rst)
        chkSteady && chkDiff > bandOff_q ##1 chkSteady |=> !atSpeed_q)
        else $error("at-speed held beyond the wide band");

    a_above_off_motor: assert property (@(posedge clock) disable iff (rst)
        !drive.motorOn |=> !aboveThr_q)
        else $error("over-threshold set while output off");

    a_above_accel_set: assert property (@(posedge clock) disable iff (rst)
        drive.motorOn && drive.ramp == DSO_RAMP_ACCEL && drive.outFreq >= cfg.accelOnThr |=> aboveThr_q)
        else $error("over-threshold missed accel threshold");

    a_above_decel_clr: assert property (@(posedge clock) disable iff (rst)
        drive.ramp == DSO_RAMP_DECEL && drive.outFreq < cfg.decelOffThr |=> !aboveThr_q)
        else $error("over-threshold held below decel threshold");

    a_above_rise_cause: assert property (@(posedge clock) disable iff (rst)
        $rose(aboveThr_q) |-> $past(drive.outFreq) >= $past(cfg.accelOnThr))
        else $error("over-threshold set below accel threshold");

    a_term_pull_low: assert property (@(posedge clock) disable iff (rst)
        termSel[`DSO_FSEL_W-1:0] == `DSO_FSEL_ABOVE |=> termOe_q[0] == $past(aboveThr_q)
            && termLevel_n_q[0] == !termOe_q[0] && !termOut_q[0])
        else $error("terminal 0 does not follow its indication active low");

    a_reset_quiet: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> !running_q && !atSpeed_q && !aboveThr_q && termOe_q == '0)
        else $error("indications not inactive after reset");

    // Band between the two widths: the detector keeps its last decision
    sequence s_holdZone;
        drive.motorOn && chkDiff > bandOn_q && chkDiff <= bandOff_q;
    endsequence

    a_ind_mirror: assert property (@(posedge clock) disable iff (rst)
        !rst |=> ind_q == $past({running_q, atSpeed_q, aboveThr_q}))
        else $error("indication outputs do not follow internal state");

    a_level_inverse: assert property (@(posedge clock) disable iff (rst)
        !rst |-> termLevel_n_q == ~termOe_q)
        else $error("terminal level is not the inverse of its enable");

    a_pin_only_low: assert property (@(posedge clock) disable iff (rst)
        !rst |-> termOut_q == '0)
        else $error("open collector pin driven high");

    a_term_run_follow: assert property (@(posedge clock) disable iff (rst)
        termSel[`DSO_FSEL_W-1:0] == `DSO_FSEL_RUN |=> termOe_q[0] == $past(running_q))
        else $error("terminal 0 does not follow the run indication");

    a_term_speed_follow: assert property (@(posedge clock) disable iff (rst)
        termSel[2*`DSO_FSEL_W-1:`DSO_FSEL_W] == `DSO_FSEL_SPEED |=> termOe_q[1] == $past(atSpeed_q))
        else $error("terminal 1 does not follow the at-speed indication");

    a_term_released: assert property (@(posedge clock) disable iff (rst)
        !(termSel[`DSO_FSEL_W-1:0] inside {`DSO_FSEL_RUN, `DSO_FSEL_SPEED, `DSO_FSEL_ABOVE})
            |=> !termOe_q[0])
        else $error("terminal 0 pulls low with an unknown function code");

    a_band_enter: assert property (@(posedge clock) disable iff (rst)
        drive.motorOn && chkDiff <= bandOn_q |=> inBand)
        else $error("band detector missed the narrow band");

    a_band_leave: assert property (@(posedge clock) disable iff (rst)
        chkDiff > bandOff_q |=> !inBand)
        else $error("band detector held beyond the wide band");

    a_band_hold: assert property (@(posedge clock) disable iff (rst)
        s_holdZone |=> inBand == $past(inBand))
        else $error("band detector changed between the two widths");

    a_band_motor_off: assert property (@(posedge clock) disable iff (rst)
        !drive.motorOn |=> !inBand)
        else $error("band detector set while output off");

    a_width_narrow: assert property (@(posedge clock) disable iff (rst)
        !rst |=> 32'(bandOn_q) * `DSO_PCT_DEN <= 32'($past(cfg.maxFreq)) * `DSO_FON_PCT
            && (32'(bandOn_q) + 32'd1) * `DSO_PCT_DEN > 32'($past(cfg.maxFreq)) * `DSO_FON_PCT)
        else $error("narrow band width is not one percent of maximum");

    a_width_wide: assert property (@(posedge clock) disable iff (rst)
        !rst |=> 32'(bandOff_q) * `DSO_PCT_DEN <= 32'($past(cfg.maxFreq)) * `DSO_FOFF_PCT
            && (32'(bandOff_q) + 32'd1) * `DSO_PCT_DEN > 32'($past(cfg.maxFreq)) * `DSO_FOFF_PCT)
        else $error("wide band width is not two percent of maximum");

    a_above_accel_hold: assert property (@(posedge clock) disable iff (rst)
        drive.motorOn && drive.ramp == DSO_RAMP_ACCEL && drive.outFreq < cfg.accelOnThr
            |=> aboveThr_q == $past(aboveThr_q))
        else $error("over-threshold changed below accel threshold");

    a_above_decel_hold: assert property (@(posedge clock) disable iff (rst)
        drive.motorOn && drive.ramp == DSO_RAMP_DECEL && drive.outFreq >= cfg.decelOffThr
            |=> aboveThr_q == $past(aboveThr_q))
        else $error("over-threshold changed above decel threshold");

    // A short reset can drop an indication too, so that edge is left out
    a_above_fall_cause: assert property (@(posedge clock) disable iff (rst)
        $fell(aboveThr_q) && !$past(rst) |-> !$past(drive.motorOn)
            || $past(drive.outFreq) < $past(cfg.decelOffThr)
            || !($past(drive.ramp) inside {DSO_RAMP_CONST, DSO_RAMP_ACCEL, DSO_RAMP_DECEL}))
        else $error("over-threshold cleared above decel threshold");

    a_run_fall_cause: assert property (@(posedge clock) disable iff (rst)
        $fell(running_q) && !$past(rst) |-> !$past(drive.runMode))
        else $error("run indication cleared while in run mode");

    a_speed_rise_cause: assert property (@(posedge clock) disable iff (rst)
        $rose(atSpeed_q) |-> $past(drive.motorOn) && $past(drive.ramp) == DSO_RAMP_CONST && $past(inBand))
        else $error("at-speed set away from the target frequency");

endmodule
`default_nettype wire

// ===== tb/dso_term_reader.sv
// Controller side of the two open-collector status terminals
`timescale 1ns/1ps
`default_nettype none
`include "dso_regs.svh"

module dso_term_reader
(
    input  wire logic [`DSO_NUM_TERM-1:0] termOe,
    output logic      [`DSO_NUM_TERM-1:0] lineLevel
);
    // Pull-up holds a released line high, so a stale level never shows
    assign lineLevel = ~termOe;
endmodule
`default_nettype wire

// ===== tb/tb_dso_status_outputs.sv
// Self-checking bench for the drive status outputs
`timescale 1ns/1ps
`default_nettype none
`include "dso_regs.svh"
`define CHK(nm, exp, got) \
    begin cmp_count++; if ((got) !== (exp)) begin \
        $display("ERROR %s expected %0h seen %0h", nm, exp, got); err_total++; end end

module tb_dso_status_outputs
    import dso_pkg::*;
;
    logic        clock;
    logic        rst;
    dso_drive_t  drive;
    dso_cfg_t    cfg;
    logic [15:0] termSel;
    dso_ind_t    ind_q;
    logic [1:0]  termOut_q;
    logic [1:0]  termOe_q;
    logic [1:0]  termLevel_n_q;
    logic [1:0]  lineLevel;
    int          err_total;
    int          cmp_count;

    dso_status_outputs u_dso_status_outputs (
        .clock         (clock),
        .rst           (rst),
        .drive         (drive),
        .cfg           (cfg),
        .termSel       (termSel),
        .ind_q         (ind_q),
        .termOut_q     (termOut_q),
        .termOe_q      (termOe_q),
        .termLevel_n_q (termLevel_n_q)
    );

    dso_term_reader u_dso_term_reader (
        .termOe    (termOe_q),
        .lineLevel (lineLevel)
    );

    initial clock = 1'b0;
    always #2 clock = ~clock;

    task report_and_stop;
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Drive one state, then wait past the longest indication latency
    task step(input logic rm, input logic mo, input dso_ramp_t rp, input logic [15:0] f);
        @(negedge clock);
        drive = '{runMode: rm, motorOn: mo, ramp: rp, outFreq: f};
        repeat (5) @(negedge clock);
    endtask

    task chk_term(input logic [1:0] expOe);
        `CHK("termOe", expOe, termOe_q)
        `CHK("termLevel_n", ~expOe, termLevel_n_q)
        `CHK("lineLevel", ~expOe, lineLevel)
        `CHK("termOut", 2'b00, termOut_q)
    endtask

    // Stop mode, so only an at-speed or over-threshold terminal can pull low
    task expect_bit(input logic mo, input dso_ramp_t rp, input logic [15:0] f, input int b, input logic e);
        step(1'b0, mo, rp, f);
        `CHK("termOe bit", e, termOe_q[b])
        `CHK("lineLevel bit", ~e, lineLevel[b])
    endtask

    task test_reset;
        repeat (11) @(negedge clock);
        `CHK("ind in reset", 3'b000, ind_q)
        chk_term(2'b00);
        @(negedge clock);
        rst = 1'b0;
        repeat (5) @(negedge clock);
        `CHK("running after reset", 1'b1, ind_q.running)
    endtask

    // Run indication holds once set, so stop mode first re-arms the start gate
    task test_run;
        step(1'b0, 1'b1, DSO_RAMP_CONST, 16'h0064);
        `CHK("running in stop first", 1'b0, ind_q.running)
        step(1'b1, 1'b1, DSO_RAMP_CONST, 16'h0064);
        `CHK("running at start freq", 1'b0, ind_q.running)
        chk_term(2'b00);
        step(1'b1, 1'b1, DSO_RAMP_ACCEL, 16'h0065);
        `CHK("running above start", 1'b1, ind_q.running)
        chk_term(2'b01);
        step(1'b0, 1'b1, DSO_RAMP_CONST, 16'h0065);
        `CHK("running in stop", 1'b0, ind_q.running)
        chk_term(2'b00);
    endtask

    // Target 500, max 1000: on within 10, off beyond 20
    task test_speed;
        expect_bit(1'b1, DSO_RAMP_CONST, 16'h01ff, 1, 1'b0);
        expect_bit(1'b1, DSO_RAMP_CONST, 16'h01fe, 1, 1'b1);
        `CHK("atSpeed", 1'b1, ind_q.atSpeed)
        expect_bit(1'b1, DSO_RAMP_CONST, 16'h0208, 1, 1'b1);
        expect_bit(1'b1, DSO_RAMP_CONST, 16'h0209, 1, 1'b0);
        expect_bit(1'b1, DSO_RAMP_CONST, 16'h0203, 1, 1'b0);
        expect_bit(1'b1, DSO_RAMP_CONST, 16'h01f4, 1, 1'b1);
        expect_bit(1'b1, DSO_RAMP_ACCEL, 16'h01f4, 1, 1'b0);
        expect_bit(1'b1, DSO_RAMP_DECEL, 16'h01f4, 1, 1'b0);
        expect_bit(1'b0, DSO_RAMP_CONST, 16'h01f4, 1, 1'b0);
    endtask

    // Turn on at 1000 accelerating, off below 800 decelerating
    task test_above;
        termSel = {`DSO_FSEL_SPEED, `DSO_FSEL_ABOVE};
        expect_bit(1'b1, DSO_RAMP_ACCEL, 16'h03e7, 0, 1'b0);
        expect_bit(1'b1, DSO_RAMP_ACCEL, 16'h03e8, 0, 1'b1);
        `CHK("aboveThr", 1'b1, ind_q.aboveThr)
        expect_bit(1'b1, DSO_RAMP_DECEL, 16'h0320, 0, 1'b1);
        expect_bit(1'b1, DSO_RAMP_DECEL, 16'h031f, 0, 1'b0);
        expect_bit(1'b1, DSO_RAMP_ACCEL, 16'h0384, 0, 1'b0);
        expect_bit(1'b1, DSO_RAMP_CONST, 16'h03e8, 0, 1'b1);
        expect_bit(1'b0, DSO_RAMP_CONST, 16'h03e8, 0, 1'b0);
        expect_bit(1'b1, DSO_RAMP_CONST, 16'h03e8, 0, 1'b1);
        termSel = {`DSO_FSEL_SPEED, 8'h05};
        expect_bit(1'b1, DSO_RAMP_CONST, 16'h03e8, 0, 1'b0);
    endtask

    // Mid-run reset: terminals drop at once, then come back from live inputs
    task test_reset_mid;
        termSel = {`DSO_FSEL_SPEED, `DSO_FSEL_ABOVE};
        step(1'b0, 1'b1, DSO_RAMP_CONST, 16'h03e8);
        `CHK("termOe before reset", 2'b01, termOe_q)
        rst = 1'b1;
        repeat (2) @(negedge clock);
        `CHK("ind in mid reset", 3'b000, ind_q)
        chk_term(2'b00);
        rst = 1'b0;
        @(negedge clock);
        chk_term(2'b00);
        repeat (4) @(negedge clock);
        chk_term(2'b01);
        `CHK("aboveThr after reset", 1'b1, ind_q.aboveThr)
    endtask

    initial
    begin
        err_total = 0;
        cmp_count = 0;
        rst = 1'b1;
        termSel = {`DSO_FSEL_SPEED, `DSO_FSEL_RUN};
        cfg = '{targetFreq: 16'h01f4, startFreq: 16'h0064, maxFreq: 16'h03e8,
                accelOnThr: 16'h03e8, decelOffThr: 16'h0320};
        drive = '{runMode: 1'b1, motorOn: 1'b1, ramp: DSO_RAMP_CONST, outFreq: 16'h0065};
        test_reset();
        test_run();
        test_speed();
        test_above();
        test_reset_mid();
        report_and_stop();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        #8000;
        err_total++;
        report_and_stop();
    end
endmodule
`default_nettype wire
